// File: hdl/ssit_top.sv
// Split-data I2C target: address decode, pointer latch, one-byte access
//
// Function
// - Receive on data input, answer on output
// - Clock only sampled; never driven, target only
// - Read: pointer write, stop, start, read byte
// - Write: address, pointer, data, each acknowledged
// - Held in reset until power-on released
// - Start/stop: data edge while clock high
// - Compare address bits 5..1 with straps
// - Address bit 0 high means read
// - Upper two address bits never compared
// - Match: acknowledge low through ninth clock
// - Latch pointer at falling edge, then acknowledge
// - Write data stored, then acknowledged
// - Common select hits all ports, else one
// - Read byte shifted out MSB first
// - Pointer kept across stop and start
// - Pointer: bits 6..3 select, 1..0 port
`timescale 1ns/1ps

module ssit_top
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       por_done,
   // Serial link pins
   input  wire logic       scl_in,
   input  wire logic       serial_data_in,
   output logic            serial_data_out,
   output logic            serial_data_out_oe_n,
   input  wire logic [4:0] address_strap_pins,
   // Register write strobe
   output logic            wr_stb,
   output logic [3:0]      wr_sel,
   output logic [1:0]      wr_port,
   output logic [3:0]      wr_port_mask,
   output logic [7:0]      wr_data,
   // Register read side
   output logic            rd_stb,
   output logic [3:0]      ptr_sel,
   output logic [1:0]      ptr_port,
   input  wire logic [7:0] rd_data
);

   //****************************************************************
   // Helpers
   //****************************************************************
   // common versus per-port
   function automatic logic [3:0] port_mask(input logic [3:0] sel,
                                            input logic [1:0] port);
      logic [3:0] m;
      m = ssit_pkg::PORT_MASK_RST;
      if ((sel == ssit_pkg::SEL_COMMON_READ) ||
          (sel == ssit_pkg::SEL_COMMON_CTRL) ||
          (sel == ssit_pkg::SEL_COMMON_TEST))
      begin
         m = ssit_pkg::PORT_MASK_ALL;
      end
      else
      begin
         m[port] = 1'b1;
      end
      return m;
   endfunction

   function automatic ssit_pkg::ssit_state_s reset_state();
      ssit_pkg::ssit_state_s r;
      r.por_s1   = 1'b0;
      r.por_s2   = 1'b0;
      r.scl_s1   = 1'b1;
      r.scl_s2   = 1'b1;
      r.scl_p    = 1'b1;
      r.sda_s1   = 1'b1;
      r.sda_s2   = 1'b1;
      r.sda_p    = 1'b1;
      r.strap_s1 = ssit_pkg::STRAP_RST;
      r.strap_s2 = ssit_pkg::STRAP_RST;
      r.state    = ssit_pkg::ST_IDLE;
      r.cnt      = ssit_pkg::BIT_CNT_RST;
      r.shreg    = ssit_pkg::BYTE_RST;
      r.is_read  = 1'b0;
      r.ptr_sel  = ssit_pkg::PTR_SEL_RST;
      r.ptr_port = ssit_pkg::PTR_PORT_RST;
      r.sda_oe_n = 1'b1;
      r.sda_lvl  = 1'b0;
      r.wr_stb   = 1'b0;
      r.wr_sel   = ssit_pkg::PTR_SEL_RST;
      r.wr_port  = ssit_pkg::PTR_PORT_RST;
      r.wr_mask  = ssit_pkg::PORT_MASK_RST;
      r.wr_data  = ssit_pkg::BYTE_RST;
      r.rd_stb   = 1'b0;
      return r;
   endfunction

   //****************************************************************
   // State record
   //****************************************************************
   ssit_pkg::ssit_state_s q;
   ssit_pkg::ssit_state_s d;

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_match;

   always_comb
   begin
      d = q;
      // Two flip-flops on every link, strap and power-on pin before use; rd_data and reset used directly
      d.por_s1   = por_done;
      d.por_s2   = q.por_s1;
      d.scl_s1   = scl_in;
      d.scl_s2   = q.scl_s1;
      d.scl_p    = q.scl_s2;
      d.sda_s1   = serial_data_in;
      d.sda_s2   = q.sda_s1;
      d.sda_p    = q.sda_s2;
      d.strap_s1 = address_strap_pins;
      d.strap_s2 = q.strap_s1;
      d.wr_stb   = 1'b0;
      d.rd_stb   = 1'b0;

      // clock edges found by sampling only
      scl_rise = q.scl_s2 & ~q.scl_p;
      scl_fall = ~q.scl_s2 & q.scl_p;
      start_seen = q.scl_s2 & q.scl_p & ~q.sda_s2 & q.sda_p;
      stop_seen  = q.scl_s2 & q.scl_p & q.sda_s2 & ~q.sda_p;
      addr_match = (q.shreg[ssit_pkg::ADDR_STRAP_MSB:
                            ssit_pkg::ADDR_STRAP_LSB] == q.strap_s2);

      if (start_seen)
      begin
         d.state    = ssit_pkg::ST_ADDR;
         d.cnt      = ssit_pkg::BIT_CNT_RST;
         d.sda_oe_n = 1'b1;
      end
      else if (stop_seen)
      begin
         // stop returns to idle, pointer kept
         d.state    = ssit_pkg::ST_IDLE;
         d.sda_oe_n = 1'b1;
      end
      else if (scl_rise)
      begin
         case (q.state)
            ssit_pkg::ST_ADDR,
            ssit_pkg::ST_PTR,
            ssit_pkg::ST_WDATA:
            begin
               // data taken from input path only
               if (q.cnt != ssit_pkg::BIT_CNT_FULL)
               begin
                  d.shreg = {q.shreg[6:0], q.sda_s2};
                  d.cnt   = q.cnt + 4'h1;
               end
            end
            ssit_pkg::ST_RDATA:
            begin
               d.cnt = q.cnt + 4'h1;
            end
            default:
            begin
               d.cnt = q.cnt;
            end
         endcase
      end
      else if (scl_fall)
      begin
         case (q.state)
            ssit_pkg::ST_ADDR:
            begin
               if (q.cnt == ssit_pkg::BIT_CNT_FULL)
               begin
                  d.is_read = (q.shreg[ssit_pkg::ADDR_DIR_BIT] ==
                               ssit_pkg::DIR_READ);
                  if (addr_match)
                  begin
                     d.state    = ssit_pkg::ST_AACK;
                     d.sda_oe_n = 1'b0;
                  end
                  else
                  begin
                     d.state    = ssit_pkg::ST_IGNORE;
                     d.sda_oe_n = 1'b1;
                  end
               end
            end
            ssit_pkg::ST_AACK:
            begin
               d.cnt = ssit_pkg::BIT_CNT_RST;
               if (q.is_read)
               begin
                  // byte from kept pointer, MSB first
                  d.shreg    = {rd_data[6:0], 1'b0};
                  d.sda_oe_n = rd_data[7];
                  d.rd_stb   = 1'b1;
                  d.state    = ssit_pkg::ST_RDATA;
               end
               else
               begin
                  d.sda_oe_n = 1'b1;
                  d.state    = ssit_pkg::ST_PTR;
               end
            end
            ssit_pkg::ST_PTR:
            begin
               if (q.cnt == ssit_pkg::BIT_CNT_FULL)
               begin
                  d.ptr_sel  = q.shreg[ssit_pkg::PTR_SEL_MSB:
                                       ssit_pkg::PTR_SEL_LSB];
                  d.ptr_port = q.shreg[ssit_pkg::PTR_PORT_MSB:
                                       ssit_pkg::PTR_PORT_LSB];
                  d.sda_oe_n = 1'b0;
                  d.state    = ssit_pkg::ST_PACK;
               end
            end
            ssit_pkg::ST_PACK:
            begin
               d.cnt      = ssit_pkg::BIT_CNT_RST;
               d.sda_oe_n = 1'b1;
               d.state    = ssit_pkg::ST_WDATA;
            end
            ssit_pkg::ST_WDATA:
            begin
               if (q.cnt == ssit_pkg::BIT_CNT_FULL)
               begin
                  d.wr_stb   = 1'b1;
                  d.wr_sel   = q.ptr_sel;
                  d.wr_port  = q.ptr_port;
                  d.wr_mask  = port_mask(q.ptr_sel, q.ptr_port);
                  d.wr_data  = q.shreg;
                  d.sda_oe_n = 1'b0;
                  d.state    = ssit_pkg::ST_WACK;
               end
            end
            ssit_pkg::ST_WACK:
            begin
               // Further bytes ignored; only one per transfer
               d.sda_oe_n = 1'b1;
               d.state    = ssit_pkg::ST_IGNORE;
            end
            ssit_pkg::ST_RDATA:
            begin
               if (q.cnt == ssit_pkg::BIT_CNT_FULL)
               begin
                  d.sda_oe_n = 1'b1;
                  d.state    = ssit_pkg::ST_RACK;
               end
               else
               begin
                  d.sda_oe_n = q.shreg[7];
                  d.shreg    = {q.shreg[6:0], 1'b0};
               end
            end
            ssit_pkg::ST_RACK:
            begin
               d.sda_oe_n = 1'b1;
               d.state    = ssit_pkg::ST_IGNORE;
            end
            default:
            begin
               d.sda_oe_n = 1'b1;
            end
         endcase
      end

      // interface held in reset until power-on released
      if (!q.por_s2)
      begin
         d          = reset_state();
         d.por_s1   = por_done;
         d.por_s2   = q.por_s1;
         d.scl_s1   = scl_in;
         d.scl_s2   = q.scl_s1;
         d.scl_p    = q.scl_s2;
         d.sda_s1   = serial_data_in;
         d.sda_s2   = q.sda_s1;
         d.sda_p    = q.sda_s2;
         d.strap_s1 = address_strap_pins;
         d.strap_s2 = q.strap_s1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         q <= reset_state();
      end
      else
      begin
         q <= d;
      end
   end

   //****************************************************************
   // Outputs
   //****************************************************************
   // output path: pull low or release
   assign serial_data_out      = q.sda_lvl;
   assign serial_data_out_oe_n = q.sda_oe_n;
   assign wr_stb               = q.wr_stb;
   assign wr_sel               = q.wr_sel;
   assign wr_port              = q.wr_port;
   assign wr_port_mask         = q.wr_mask;
   assign wr_data              = q.wr_data;
   assign rd_stb               = q.rd_stb;
   assign ptr_sel              = q.ptr_sel;
   assign ptr_port             = q.ptr_port;

endmodule

// File: hdl/ssit_pkg.sv
// Constants, states and the state record of the split-data I2C target
package ssit_pkg;

   //****************************************************************
   // Bus framing
   //****************************************************************
   localparam int unsigned BYTE_BITS = 8;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;

   // Address byte: bits 7..6 not compared, 5..1 strap, 0 direction
   localparam int unsigned ADDR_STRAP_LSB = 1;
   localparam int unsigned ADDR_STRAP_MSB = 5;
   localparam int unsigned ADDR_DIR_BIT = 0;
   localparam logic DIR_READ = 1'b1;

   //****************************************************************
   // Pointer byte: bits 6..3 register select, 1..0 port
   //****************************************************************
   localparam int unsigned PTR_SEL_LSB = 3;
   localparam int unsigned PTR_SEL_MSB = 6;
   localparam int unsigned PTR_PORT_LSB = 0;
   localparam int unsigned PTR_PORT_MSB = 1;
   localparam logic [3:0] PTR_SEL_RST = 4'h0;
   localparam logic [1:0] PTR_PORT_RST = 2'h0;

   // Register selects that act on all four ports together
   localparam logic [3:0] SEL_COMMON_READ = 4'h0;
   localparam logic [3:0] SEL_COMMON_CTRL = 4'h1;
   localparam logic [3:0] SEL_COMMON_TEST = 4'hF;
   localparam logic [3:0] PORT_MASK_ALL = 4'hF;
   localparam logic [3:0] PORT_MASK_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [4:0] STRAP_RST = 5'h00;

   //****************************************************************
   // States and state record
   //****************************************************************
   typedef enum logic [9:0] {
      ST_IDLE   = 10'h001,
      ST_ADDR   = 10'h002,
      ST_AACK   = 10'h004,
      ST_PTR    = 10'h008,
      ST_PACK   = 10'h010,
      ST_WDATA  = 10'h020,
      ST_WACK   = 10'h040,
      ST_RDATA  = 10'h080,
      ST_RACK   = 10'h100,
      ST_IGNORE = 10'h200
   } ssit_state_e;

   typedef struct packed {
      logic        por_s1;
      logic        por_s2;
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_p;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_p;
      logic [4:0]  strap_s1;
      logic [4:0]  strap_s2;
      ssit_state_e state;
      logic [3:0]  cnt;
      logic [7:0]  shreg;
      logic        is_read;
      logic [3:0]  ptr_sel;
      logic [1:0]  ptr_port;
      logic        sda_oe_n;
      logic        sda_lvl;
      logic        wr_stb;
      logic [3:0]  wr_sel;
      logic [1:0]  wr_port;
      logic [3:0]  wr_mask;
      logic [7:0]  wr_data;
      logic        rd_stb;
   } ssit_state_s;

endpackage

// File: bench/ssit_checker.sv
// Port assertions of the split-data I2C target
`timescale 1ns/1ps
module ssit_checker
(
   // Clock and reset
   input logic       clock,
   input logic       reset,
   input logic       por_done,
   // Link
   input logic       scl_in,
   input logic       serial_data_out,
   input logic       serial_data_out_oe_n,
   // Register side
   input logic       wr_stb,
   input logic [3:0] wr_sel,
   input logic [1:0] wr_port,
   input logic [3:0] wr_port_mask,
   input logic [7:0] wr_data,
   input logic       rd_stb,
   input logic [3:0] ptr_sel,
   input logic [1:0] ptr_port
);
   logic common;
   assign common = wr_sel == 4'h0 || wr_sel == 4'h1 || wr_sel == 4'hF;
   default clocking cb @(posedge clock); endclocking
   // Power-good low resets the block as well
   default disable iff (reset || !por_done);
   sequence s_scl_held;
      scl_in [*3] ##1 scl_in;
   endsequence
   sequence s_ack_held;
      !serial_data_out_oe_n [*3];
   endsequence
   property p_pull_only;
      serial_data_out == 1'b0;
   endproperty
   a_pull_only: assert property (p_pull_only)
      else $error("data out not at pull level");
   property p_wr_pulse;
      wr_stb |=> !wr_stb;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe too long");
   property p_rd_pulse;
      rd_stb |=> !rd_stb;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe too long");
   property p_mask_all;
      wr_stb && common |-> wr_port_mask == 4'hF;
   endproperty
   a_mask_all: assert property (p_mask_all)
      else $error("common write not on all ports");
   property p_mask_one;
      wr_stb && !common |-> wr_port_mask == 4'h1 << wr_port;
   endproperty
   a_mask_one: assert property (p_mask_one)
      else $error("port write mask wrong");
   property p_wr_ack;
      wr_stb |-> ##[0:1] !serial_data_out_oe_n;
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("write not acknowledged");
   property p_ack_hold;
      $fell(serial_data_out_oe_n) |=> s_ack_held;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("low pulse too short");
   property p_high_stable;
      s_scl_held |-> $stable(serial_data_out_oe_n);
   endproperty
   a_high_stable: assert property (p_high_stable)
      else $error("data out moved while clock high");
   property p_ptr_kept;
      rd_stb |-> $stable(ptr_sel) && $stable(ptr_port);
   endproperty
   a_ptr_kept: assert property (p_ptr_kept)
      else $error("pointer moved during read");
   property p_wr_stand;
      !wr_stb |=> $stable(wr_data) || wr_stb;
   endproperty
   a_wr_stand: assert property (p_wr_stand)
      else $error("write data changed without strobe");
endmodule

bind ssit_top ssit_checker u_chk (.clock(clock), .reset(reset),
   .por_done(por_done), .scl_in(scl_in),
   .serial_data_out(serial_data_out),
   .serial_data_out_oe_n(serial_data_out_oe_n), .wr_stb(wr_stb),
   .wr_sel(wr_sel), .wr_port(wr_port), .wr_port_mask(wr_port_mask),
   .wr_data(wr_data), .rd_stb(rd_stb), .ptr_sel(ptr_sel),
   .ptr_port(ptr_port));

// File: bench/ssit_host.sv
// Host controller model of the serial link
`timescale 1ns/1ps
module ssit_host
(
   // Clock
   input logic  clock,
   // Link
   input logic  bus_lvl,
   output logic scl,
   output logic sda
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Clock edges land 3 ns after the system edge, fixed phase
   task automatic bit_x(input logic b, output logic r);
      @(posedge clock);
      sda <= #1 b;
      repeat (3) @(posedge clock);
      scl <= #3 1'b1;
      repeat (2) @(posedge clock);
      r = bus_lvl;
      repeat (2) @(posedge clock);
      scl <= #3 1'b0;
   endtask
   task automatic edge_c(input logic st);
      @(posedge clock);
      sda <= #1 st;
      repeat (3) @(posedge clock);
      scl <= #3 1'b1;
      repeat (4) @(posedge clock);
      sda <= #1 !st;
      repeat (4) @(posedge clock);
      if (st)
         scl <= #3 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q[i]);
      bit_x(1'b1, ack);
   endtask
endmodule

// File: bench/ssit_top_tb.sv
// Self-checking bench of the split-data I2C target
`timescale 1ns/1ps
module ssit_top_tb;
   logic        clock, reset, por_done, scl, sda, oe_n, dout;
   logic        wr_stb, rd_stb;
   logic [4:0]  strap;
   logic [3:0]  wr_sel, wr_mask, ptr_sel;
   logic [1:0]  wr_port, ptr_port;
   logic [7:0]  wr_data, rd_data, key, r;
   logic [17:0] wq[$];
   logic [17:0] rq[$];
   int          error_cnt, tests_run, seed;
   wire         bus_lvl = oe_n ? 1'b1 : dout;
   wire [17:0]  w_seen = {wr_sel, wr_port, wr_mask, wr_data};
   wire [17:0]  r_seen = {12'h000, ptr_sel, ptr_port};

   ssit_top u_dut (.clock(clock), .reset(reset), .por_done(por_done),
      .scl_in(scl), .serial_data_in(sda), .serial_data_out(dout),
      .serial_data_out_oe_n(oe_n), .address_strap_pins(strap),
      .wr_stb(wr_stb), .wr_sel(wr_sel), .wr_port(wr_port),
      .wr_port_mask(wr_mask), .wr_data(wr_data), .rd_stb(rd_stb),
      .ptr_sel(ptr_sel), .ptr_port(ptr_port), .rd_data(rd_data));
   ssit_host u_host (.clock(clock), .bus_lvl(bus_lvl), .scl(scl),
      .sda(sda));

   always #4 clock = ~clock;
   always @(posedge clock)
      rd_data <= {ptr_sel, ptr_port, 2'b10} ^ key;

   task automatic check(input string nm, input logic [17:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Notes taken off as strobes appear
   always @(posedge clock)
   begin
      if (wr_stb === 1'b1)
         check("wr", w_seen, wq.size() ? wq.pop_front() : 'x);
      if (rd_stb === 1'b1)
         check("rd", r_seen, rq.size() ? rq.pop_front() : 'x);
   end

   task automatic addr(input logic dir, input logic [1:0] up,
                       input logic [4:0] flip, input logic lvl);
      logic [7:0] q;
      logic       a;
      u_host.edge_c(1'b1);
      u_host.byte_x({up, strap ^ flip, dir}, q, a);
      check("addr ack", 18'(a), 18'(lvl));
   endtask

   task automatic send(input logic [7:0] d, input logic lvl);
      logic [7:0] q;
      logic       a;
      u_host.byte_x(d, q, a);
      check("byte ack", 18'(a), 18'(lvl));
   endtask

   task automatic wr(input logic [3:0] sel, input logic [1:0] port,
                     input logic [1:0] up);
      logic [7:0] d;
      logic [3:0] m;
      d = 8'($random(seed));
      m = (sel < 4'h2 || sel == 4'hF) ? 4'hF : 4'h1 << port;
      wq.push_back({sel, port, m, d});
      addr(1'b0, up, 5'h00, 1'b0);
      send({d[7], sel, d[2], port}, 1'b0);
      send(d, 1'b0);
      u_host.edge_c(1'b0);
   endtask

   // pointer write, stop, restart as read
   task automatic rd(input logic [3:0] sel, input logic [1:0] port);
      logic [7:0] q;
      logic       a;
      key = 8'($random(seed));
      rq.push_back({12'h000, sel, port});
      addr(1'b0, port, 5'h00, 1'b0);
      send({port[0], sel, port[1], port}, 1'b0);
      u_host.edge_c(1'b0);
      addr(1'b1, sel[1:0], 5'h00, 1'b0);
      u_host.byte_x(8'hFF, q, a);
      check("rdata", 18'(q), 18'({sel, port, 2'b10} ^ key));
      u_host.edge_c(1'b0);
   endtask

   initial
   begin
      clock = 1'b0;
      reset = 1'b1;
      por_done = 1'b0;
      seed = 88327;
      strap = 5'($random(seed));
      key = 8'h00;
      rd_data = 8'h00;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      addr(1'b0, 2'h0, 5'h00, 1'b1);
      u_host.edge_c(1'b0);
      $display("test power hold done");
      por_done <= 1'b1;
      repeat (10) @(posedge clock);
      for (int i = 0; i < 16; i++)
      begin
         r = 8'($random(seed));
         wr(i[3:0], r[1:0], i[1:0]);
      end
      $display("test write done");
      for (int i = 0; i < 8; i++)
      begin
         r = 8'($random(seed));
         rd(r[5:2], r[1:0]);
      end
      $display("test read done");
      // each strap bit compared; silent after
      for (int i = 0; i < 5; i++)
      begin
         addr(1'b0, 2'h3, 5'h01 << i, 1'b1);
         send(8'h00, 1'b1);
         wr(4'h2, 2'(i), 2'h1);
      end
      $display("test mismatch done");
      check("left", 18'(wq.size() + rq.size()), 18'h00000);
      end_sim();
   end

   initial
   begin
      #400000;
      error_cnt++;
      end_sim();
   end
endmodule
